/* design/cbd_map.svh */
/*
  constants for the carry-bit, branch and no-operation decoder: opcodes,
  field positions and cycle counts.
  assumes: included by bare name from the decoder, target and core files.
*/
`ifndef CBD_MAP_SVH
`define CBD_MAP_SVH

// ****************************************
// opcodes
// ****************************************
`define CBD_OP_ANL_C_NBIT   8'hb0
`define CBD_OP_ORL_C_BIT    8'h72
`define CBD_OP_ORL_C_NBIT   8'ha0
`define CBD_OP_MOV_C_BIT    8'ha2
`define CBD_OP_MOV_BIT_C    8'h92
`define CBD_OP_FAR_CALL     8'h12
`define CBD_OP_RET          8'h22
`define CBD_OP_INT_RET      8'h32
`define CBD_OP_FAR_JUMP     8'h02
`define CBD_OP_REL_JUMP     8'h80
`define CBD_OP_JB           8'h20
`define CBD_OP_JNB          8'h30
`define CBD_OP_JBC          8'h10
`define CBD_OP_JMP_IND      8'h73
`define CBD_OP_JZ           8'h60
`define CBD_OP_JNZ          8'h70
`define CBD_OP_CMP_DIR      8'hb5
`define CBD_OP_CMP_IMM      8'hb4
`define CBD_OP_DEC_DIR      8'hd5
`define CBD_OP_NOP          8'h00
// low five bits of the page call and page jump sets
`define CBD_PAGE_CALL_LO    5'h11
`define CBD_PAGE_JUMP_LO    5'h01
// upper five bits of the eight-register blocks
`define CBD_CMP_REG_HI      5'h17
`define CBD_DEC_REG_HI      5'h1b
// upper seven bits of the indirect compare pair
`define CBD_CMP_IND_HI      7'h5b
// upper seven bits of the external data move pairs
`define CBD_XMOV_RD_HI      7'h71
`define CBD_XMOV_WR_HI      7'h79

// ****************************************
// fields and timing
// ****************************************
`define CBD_PAGE_MSB        7
`define CBD_PAGE_LSB        5
`define CBD_REG_MSB         2
`define CBD_CYC_ONE         2'h1
`define CBD_CYC_TWO         2'h2
`define CBD_LEN_ONE         2'h1
`define CBD_LEN_TWO         2'h2
`define CBD_LEN_THREE       2'h3
`define CBD_PC_RESET        16'h0000

`endif

/* design/cbd_pkg.sv */
/*
  types shared by the decoder and its execution helpers.
  assumes: cbd_map.svh on the include path.
*/
package cbd_pkg;

  // ****************************************
  // operation classes
  // ****************************************
  typedef enum logic [4:0] {
    CBD_NOP, CBD_ANDN_C, CBD_OR_C, CBD_ORN_C, CBD_MOV_C, CBD_MOV_BIT,
    CBD_PCALL, CBD_FCALL, CBD_RET, CBD_IRET, CBD_PJUMP, CBD_FJUMP,
    CBD_RJUMP, CBD_JB, CBD_JNB, CBD_JBC, CBD_JIND, CBD_JZ, CBD_JNZ,
    CBD_CMP_DIR, CBD_CMP_IMM, CBD_CMP_REG, CBD_CMP_IND, CBD_DJ_REG,
    CBD_DJ_DIR, CBD_XMOV, CBD_OTHER
  } cbd_op_t;

  // ****************************************
  // decoded instruction
  // ****************************************
  typedef struct packed {
    cbd_op_t    op;     // operation class
    logic [1:0] len;    // length in bytes
    logic [1:0] cyc;    // machine cycles
    logic [2:0] reg_no; // working register
  } cbd_dec_t;

  // ****************************************
  // execution states, gray along fetch path
  // ****************************************
  typedef enum logic [2:0] {
    CBD_S_FETCH = 3'h0,
    CBD_S_OPND1 = 3'h1,
    CBD_S_OPND2 = 3'h3,
    CBD_S_EXEC  = 3'h2,
    CBD_S_DONE  = 3'h6
  } cbd_state_t;

  // ****************************************
  // core state seen and changed by the block
  // ****************************************
  typedef struct packed {
    logic [15:0] pc;    // program counter
    logic        carry; // carry flag
  } cbd_core_t;

endpackage

/* design/cbd_decode.sv */
/*
  combinational opcode decoder: class, length, cycles, register.
  assumes: opcode byte valid whenever read.
*/
`include "cbd_map.svh"

module cbd_decode (
  // opcode in
  input  wire logic [7:0]       opcode,
  // decoded out
  output cbd_pkg::cbd_dec_t     dec
);

  // ****************************************
  // group matches
  // ****************************************
  wire logic is_pcall = (opcode[4:0] == `CBD_PAGE_CALL_LO);   // page call set
  wire logic is_pjump = (opcode[4:0] == `CBD_PAGE_JUMP_LO);   // page jump set
  wire logic is_creg  = (opcode[7:3] == `CBD_CMP_REG_HI);
  wire logic is_dreg  = (opcode[7:3] == `CBD_DEC_REG_HI);
  wire logic is_cind  = (opcode[7:1] == `CBD_CMP_IND_HI);
  wire logic is_xmov  = (opcode[7:1] == `CBD_XMOV_RD_HI) ||
                        (opcode[7:1] == `CBD_XMOV_WR_HI) ||
                        (opcode == 8'he0) || (opcode == 8'hf0);

  // class selection
  always_comb begin
    dec.op     = cbd_pkg::CBD_OTHER;
    dec.len    = `CBD_LEN_ONE;
    dec.cyc    = `CBD_CYC_ONE;
    dec.reg_no = opcode[`CBD_REG_MSB:0];
    if (is_pcall) begin
      dec.op = cbd_pkg::CBD_PCALL; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO;
    end else if (is_pjump) begin
      dec.op = cbd_pkg::CBD_PJUMP; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO;
    end else if (is_creg) begin
      dec.op = cbd_pkg::CBD_CMP_REG; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO;
    end else if (is_dreg) begin
      dec.op = cbd_pkg::CBD_DJ_REG; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO;
    end else if (is_cind) begin
      dec.op = cbd_pkg::CBD_CMP_IND; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO;
    end else if (is_xmov) begin
      dec.op = cbd_pkg::CBD_XMOV; dec.cyc = `CBD_CYC_TWO;
    end else begin
      case (opcode)
        `CBD_OP_ANL_C_NBIT: begin dec.op = cbd_pkg::CBD_ANDN_C; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_ORL_C_BIT:  begin dec.op = cbd_pkg::CBD_OR_C;   dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_ORL_C_NBIT: begin dec.op = cbd_pkg::CBD_ORN_C;  dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_MOV_C_BIT:  begin dec.op = cbd_pkg::CBD_MOV_C;  dec.len = `CBD_LEN_TWO; end
        `CBD_OP_MOV_BIT_C:  begin dec.op = cbd_pkg::CBD_MOV_BIT; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_FAR_CALL:   begin dec.op = cbd_pkg::CBD_FCALL; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_RET:        begin dec.op = cbd_pkg::CBD_RET;   dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_INT_RET:    begin dec.op = cbd_pkg::CBD_IRET;  dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_FAR_JUMP:   begin dec.op = cbd_pkg::CBD_FJUMP; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_REL_JUMP:   begin dec.op = cbd_pkg::CBD_RJUMP; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_JB:         begin dec.op = cbd_pkg::CBD_JB;  dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_JNB:        begin dec.op = cbd_pkg::CBD_JNB; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_JBC:        begin dec.op = cbd_pkg::CBD_JBC; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_JMP_IND:    begin dec.op = cbd_pkg::CBD_JIND; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_JZ:         begin dec.op = cbd_pkg::CBD_JZ;  dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_JNZ:        begin dec.op = cbd_pkg::CBD_JNZ; dec.len = `CBD_LEN_TWO; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_CMP_DIR:    begin dec.op = cbd_pkg::CBD_CMP_DIR; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_CMP_IMM:    begin dec.op = cbd_pkg::CBD_CMP_IMM; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_DEC_DIR:    begin dec.op = cbd_pkg::CBD_DJ_DIR; dec.len = `CBD_LEN_THREE; dec.cyc = `CBD_CYC_TWO; end
        `CBD_OP_NOP:        begin dec.op = cbd_pkg::CBD_NOP; end
        default:            begin dec.op = cbd_pkg::CBD_OTHER; end
      endcase
    end
  end

endmodule // cbd_decode

/* design/cbd_target.sv */
/*
  branch target arithmetic: page, far, relative and indirect targets.
  assumes: pc_next is the address after the whole instruction.
*/
`include "cbd_map.svh"

module cbd_target (
  // inputs
  input  wire logic [15:0] pc_next,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  byte1,
  input  wire logic [7:0]  byte2,
  input  wire logic [7:0]  rel,
  input  wire logic [7:0]  acc,
  input  wire logic [15:0] data_pointer,
  // targets
  output logic      [15:0] page_tgt,
  output logic      [15:0] far_tgt,
  output logic      [15:0] rel_tgt,
  output logic      [15:0] ind_tgt
);

  // page target: pc_next top five bits, opcode top bits, then second byte
  assign page_tgt = {pc_next[15:11], opcode[`CBD_PAGE_MSB:`CBD_PAGE_LSB], byte1};
  // far target, high byte first
  assign far_tgt  = {byte1, byte2};
  // signed displacement
  assign rel_tgt  = pc_next + {{8{rel[7]}}, rel};
  // accumulator plus data pointer
  assign ind_tgt  = data_pointer + {8'h00, acc};

endmodule // cbd_target

/* design/cbd_core.sv */
/*
  carry-bit, branch and no-operation execution unit of the 8-bit core.
  assumes: code memory answers an address in the next cycle; bit, data
  and stack values are supplied by the rest of the core in the cycle
  they are requested; one instruction at a time.
*/
`include "cbd_map.svh"

module cbd_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // code memory
  input  wire logic [7:0]  code_data,
  output logic      [15:0] code_addr,
  // core state inputs
  input  wire logic        bit_value,
  input  wire logic [7:0]  acc,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  operand_value,
  input  wire logic [15:0] stack_pc,
  // core effects
  output logic             carry,
  output logic             bit_we,
  output logic [7:0]       bit_addr,
  output logic             bit_wdata,
  output logic             push_we,
  output logic [15:0]      push_pc,
  output logic             pop_req,
  output logic             int_level_end,
  output logic             reg_we,
  output logic [2:0]       reg_no,
  output logic [7:0]       reg_wdata,
  output logic             dir_we,
  output logic [7:0]       dir_addr,
  output logic [7:0]       dir_wdata,
  output logic             other_op,
  output logic             instr_done
);

  // ****************************************
  // state
  // ****************************************
  cbd_pkg::cbd_state_t state_r;     // sequencer state
  cbd_pkg::cbd_state_t state_nxt;
  cbd_pkg::cbd_core_t  core_r;      // pc and carry
  cbd_pkg::cbd_core_t  core_nxt;
  logic [7:0]          opcode_r;    // current opcode
  logic [7:0]          byte1_r;     // first operand byte
  logic [7:0]          byte2_r;     // second operand byte
  logic [1:0]          cyc_cnt_r;   // machine cycles spent
  logic [1:0]          cyc_cnt_nxt;
  logic [15:0]         fetch_r;     // next code address
  logic [15:0]         fetch_nxt;

  // effect registers
  logic        bit_we_r, bit_we_nxt;
  logic        bit_wd_r, bit_wd_nxt;
  logic        push_r, push_nxt;
  logic [15:0] push_pc_r, push_pc_nxt;
  logic        pop_r, pop_nxt;
  logic        iend_r, iend_nxt;
  logic        reg_we_r, reg_we_nxt;
  logic [7:0]  reg_wd_r, reg_wd_nxt;
  logic        dir_we_r, dir_we_nxt;
  logic [7:0]  dir_wd_r, dir_wd_nxt;
  logic        other_r, other_nxt;
  logic        done_r, done_nxt;

  // ****************************************
  // decode and targets
  // ****************************************
  cbd_pkg::cbd_dec_t dec;            // decode of latched opcode

  cbd_decode u_decode (
    .opcode (opcode_r),
    .dec    (dec)
  );

  wire logic [15:0] pc_next = fetch_r;  // address after the instruction
  wire logic [7:0]  rel_byte = (dec.len == `CBD_LEN_THREE) ? byte2_r : byte1_r;
  logic [15:0]      page_tgt, far_tgt, rel_tgt, ind_tgt;

  cbd_target u_target (
    .pc_next      (pc_next),
    .opcode       (opcode_r),
    .byte1        (byte1_r),
    .byte2        (byte2_r),
    .rel          (rel_byte),
    .acc          (acc),
    .data_pointer (data_pointer),
    .page_tgt     (page_tgt),
    .far_tgt      (far_tgt),
    .rel_tgt      (rel_tgt),
    .ind_tgt      (ind_tgt)
  );

  // ****************************************
  // operand helpers
  // ****************************************
  wire logic       need1 = (dec.len != `CBD_LEN_ONE);
  wire logic       need2 = (dec.len == `CBD_LEN_THREE);
  wire logic [7:0] dec_val = operand_value - 8'h01;           // decremented operand
  wire logic [7:0] cmp_rhs = (dec.op == cbd_pkg::CBD_CMP_DIR) ? operand_value : byte1_r;
  wire logic [7:0] cmp_lhs = (dec.op == cbd_pkg::CBD_CMP_REG ||
                              dec.op == cbd_pkg::CBD_CMP_IND) ? operand_value : acc;
  wire logic       unequal = (cmp_lhs != cmp_rhs);
  wire logic       in_exec = (state_r == cbd_pkg::CBD_S_EXEC);

  // ****************************************
  // execution and sequencing
  // ****************************************
  always_comb begin
    state_nxt   = state_r;
    core_nxt    = core_r;
    cyc_cnt_nxt = cyc_cnt_r;
    fetch_nxt   = fetch_r;
    bit_we_nxt  = 1'b0;
    bit_wd_nxt  = 1'b0;
    push_nxt    = 1'b0;
    push_pc_nxt = push_pc_r;
    pop_nxt     = 1'b0;
    iend_nxt    = 1'b0;
    reg_we_nxt  = 1'b0;
    reg_wd_nxt  = reg_wd_r;
    dir_we_nxt  = 1'b0;
    dir_wd_nxt  = dir_wd_r;
    other_nxt   = 1'b0;
    done_nxt    = 1'b0;
    case (state_r)
      // opcode byte arrives
      cbd_pkg::CBD_S_FETCH: begin
        fetch_nxt   = fetch_r + 16'h0001;
        cyc_cnt_nxt = `CBD_CYC_ONE;
        state_nxt   = cbd_pkg::CBD_S_OPND1;
      end
      // first operand byte, or straight to execute
      cbd_pkg::CBD_S_OPND1: begin
        if (need1) begin
          fetch_nxt = fetch_r + 16'h0001;
          state_nxt = need2 ? cbd_pkg::CBD_S_OPND2 : cbd_pkg::CBD_S_EXEC;
        end else begin
          state_nxt = cbd_pkg::CBD_S_EXEC;
        end
      end
      // second operand byte
      cbd_pkg::CBD_S_OPND2: begin
        fetch_nxt = fetch_r + 16'h0001;
        state_nxt = cbd_pkg::CBD_S_EXEC;
      end
      // one machine cycle per pass; effects on the last
      cbd_pkg::CBD_S_EXEC: begin
        if (cyc_cnt_r != dec.cyc) begin
          cyc_cnt_nxt = cyc_cnt_r + 2'h1;
        end else begin
          state_nxt = cbd_pkg::CBD_S_DONE;
          done_nxt  = 1'b1;
          core_nxt.pc = pc_next;
          case (dec.op)
            cbd_pkg::CBD_ANDN_C: core_nxt.carry = core_r.carry & ~bit_value;
            cbd_pkg::CBD_OR_C:   core_nxt.carry = core_r.carry | bit_value;
            cbd_pkg::CBD_ORN_C:  core_nxt.carry = core_r.carry | ~bit_value;
            cbd_pkg::CBD_MOV_C:  core_nxt.carry = bit_value;
            cbd_pkg::CBD_MOV_BIT: begin
              bit_we_nxt = 1'b1;
              bit_wd_nxt = core_r.carry;
            end
            cbd_pkg::CBD_PCALL: begin
              push_nxt    = 1'b1;
              push_pc_nxt = pc_next;
              core_nxt.pc = page_tgt;
            end
            cbd_pkg::CBD_FCALL: begin
              push_nxt    = 1'b1;
              push_pc_nxt = pc_next;
              core_nxt.pc = far_tgt;
            end
            cbd_pkg::CBD_RET: begin
              pop_nxt     = 1'b1;
              core_nxt.pc = stack_pc;
            end
            cbd_pkg::CBD_IRET: begin
              pop_nxt     = 1'b1;
              iend_nxt    = 1'b1;
              core_nxt.pc = stack_pc;
            end
            cbd_pkg::CBD_PJUMP: core_nxt.pc = page_tgt;
            cbd_pkg::CBD_FJUMP: core_nxt.pc = far_tgt;
            cbd_pkg::CBD_RJUMP: core_nxt.pc = rel_tgt;
            cbd_pkg::CBD_JB:  if (bit_value)  core_nxt.pc = rel_tgt;
            cbd_pkg::CBD_JNB: if (!bit_value) core_nxt.pc = rel_tgt;
            cbd_pkg::CBD_JBC: if (bit_value) begin
              core_nxt.pc = rel_tgt;
              bit_we_nxt  = 1'b1;
              bit_wd_nxt  = 1'b0;
            end
            cbd_pkg::CBD_JIND: core_nxt.pc = ind_tgt;
            cbd_pkg::CBD_JZ:  if (acc == 8'h00) core_nxt.pc = rel_tgt;
            cbd_pkg::CBD_JNZ: if (acc != 8'h00) core_nxt.pc = rel_tgt;
            cbd_pkg::CBD_CMP_DIR, cbd_pkg::CBD_CMP_IMM,
            cbd_pkg::CBD_CMP_REG, cbd_pkg::CBD_CMP_IND: begin
              core_nxt.carry = (cmp_lhs < cmp_rhs);
              if (unequal) core_nxt.pc = rel_tgt;
            end
            cbd_pkg::CBD_DJ_REG: begin
              reg_we_nxt = 1'b1;
              reg_wd_nxt = dec_val;
              if (dec_val != 8'h00) core_nxt.pc = rel_tgt;
            end
            cbd_pkg::CBD_DJ_DIR: begin
              dir_we_nxt = 1'b1;
              dir_wd_nxt = dec_val;
              if (dec_val != 8'h00) core_nxt.pc = rel_tgt;
            end
            cbd_pkg::CBD_XMOV: ;
            cbd_pkg::CBD_OTHER: other_nxt = 1'b1;
            default: ;
          endcase
          fetch_nxt = core_nxt.pc;
        end
      end
      // fetch of the next opcode issued
      cbd_pkg::CBD_S_DONE: state_nxt = cbd_pkg::CBD_S_FETCH;
      default:             state_nxt = cbd_pkg::CBD_S_FETCH;
    endcase
  end

  // ****************************************
  // sequencer registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= cbd_pkg::CBD_S_FETCH;
      core_r    <= '0;
      cyc_cnt_r <= 2'h0;
      fetch_r   <= `CBD_PC_RESET;
    end else begin
      state_r   <= state_nxt;
      core_r    <= core_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
      fetch_r   <= fetch_nxt;
    end
  end

  // instruction bytes captured as they arrive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opcode_r <= `CBD_OP_NOP;
      byte1_r  <= 8'h00;
      byte2_r  <= 8'h00;
    end else begin
      if (state_r == cbd_pkg::CBD_S_FETCH) opcode_r <= code_data;
      if (state_r == cbd_pkg::CBD_S_OPND1 && need1) byte1_r <= code_data;
      if (state_r == cbd_pkg::CBD_S_OPND2) byte2_r <= code_data;
    end
  end

  // effect strobes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {bit_we_r, bit_wd_r, push_r, pop_r, iend_r} <= 5'h00;
      {reg_we_r, dir_we_r, other_r, done_r}       <= 4'h0;
      push_pc_r <= 16'h0000;
      reg_wd_r  <= 8'h00;
      dir_wd_r  <= 8'h00;
    end else begin
      {bit_we_r, bit_wd_r, push_r, pop_r, iend_r} <= {bit_we_nxt, bit_wd_nxt, push_nxt,
                                                      pop_nxt, iend_nxt};
      {reg_we_r, dir_we_r, other_r, done_r}       <= {reg_we_nxt, dir_we_nxt, other_nxt,
                                                      done_nxt};
      push_pc_r <= push_pc_nxt;
      reg_wd_r  <= reg_wd_nxt;
      dir_wd_r  <= dir_wd_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign code_addr     = fetch_r;
  assign carry         = core_r.carry;
  assign bit_we        = bit_we_r;
  assign bit_addr      = byte1_r;
  assign bit_wdata     = bit_wd_r;
  assign push_we       = push_r;
  assign push_pc       = push_pc_r;
  assign pop_req       = pop_r;
  assign int_level_end = iend_r;
  assign reg_we        = reg_we_r;
  assign reg_no        = opcode_r[`CBD_REG_MSB:0];
  assign reg_wdata     = reg_wd_r;
  assign dir_we        = dir_we_r;
  assign dir_addr      = byte1_r;
  assign dir_wdata     = dir_wd_r;
  assign other_op      = other_r;
  assign instr_done    = done_r;

  wire logic unused_exec = in_exec;                           // debug visibility

endmodule // cbd_core

/* verif/cbd_code_mem.sv */
/*
  code memory model: the byte at the fetch address stands during the
  cycle after that address is set, so the sequencer's next edge takes it.
  assumes: the bench loads the low page by hierarchical name.
*/
module cbd_code_mem (
  // clock
  input  wire logic        clk,
  // fetch port
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255]; // low page, upper address bits ignored
  // blank code reads as no-operation
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  // asynchronous read: a registered read would hand each operand byte
  // to the sequencer one edge late, so it would latch the previous byte
  assign code_data = mem[code_addr[7:0]];
endmodule // cbd_code_mem

/* verif/cbd_core_props.sv */
/*
  port assertions for the carry and branch unit.
  assumes: bound to every cbd_core instance, one clock domain.
*/
module cbd_core_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched outputs
  input wire logic carry,
  input wire logic bit_we,
  input wire logic push_we,
  input wire logic pop_req,
  input wire logic int_level_end,
  input wire logic reg_we,
  input wire logic dir_we,
  input wire logic other_op,
  input wire logic instr_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_done_gap; instr_done |=> !instr_done [*3]; endproperty
  a_done_gap: assert property (p_done_gap) else $error("done pulses too close");
  property p_push; push_we |-> instr_done; endproperty
  a_push: assert property (p_push) else $error("push outside completion");
  property p_pop; pop_req |-> instr_done; endproperty
  a_pop: assert property (p_pop) else $error("pop outside completion");
  property p_iret; int_level_end |-> pop_req && !push_we; endproperty
  a_iret: assert property (p_iret) else $error("level end without pop");
  property p_bitw; bit_we |-> instr_done && !push_we; endproperty
  a_bitw: assert property (p_bitw) else $error("bit write misplaced");
  property p_regw; reg_we || dir_we |-> instr_done && !bit_we; endproperty
  a_regw: assert property (p_regw) else $error("operand write misplaced");
  property p_other; other_op |-> instr_done && !(bit_we || reg_we || dir_we); endproperty
  a_other: assert property (p_other) else $error("foreign op changed state");
  property p_carry; $changed(carry) |-> ##[0:3] instr_done; endproperty
  a_carry: assert property (p_carry) else $error("carry moved outside op");
  property p_pulse; push_we |=> !push_we && !pop_req; endproperty
  a_pulse: assert property (p_pulse) else $error("push longer than a cycle");
endmodule // cbd_core_props
bind cbd_core cbd_core_props i_cbd_core_props (.*);

/* verif/test_cbd_core.sv */
/*
  bench for cbd_core: runs short programs, checks carry, pulses,
  next fetch address and cycle counts.
  assumes: code memory model and checker compiled before it.
*/
module test_cbd_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, reset_n = 1'b0, bit_value = 1'b0, carry, bit_we, bit_wdata;
  logic        push_we, pop_req, int_level_end, reg_we, dir_we, other_op, instr_done;
  logic [2:0]  reg_no, rn;
  logic [7:0]  code_data, acc = 8'h00, operand_value = 8'h00, bit_addr, reg_wdata;
  logic [7:0]  dir_addr, dir_wdata, rw, ba;
  logic [15:0] code_addr, push_pc, data_pointer = 16'h0000, stack_pc = 16'h0000, pp;
  logic [6:0]  fl;   // {push, pop, level end, bit, reg, dir, other}
  logic        bw, cy;
  int          mismatches = 0, compares = 0;
  cbd_core i_cbd_core (.*);
  cbd_code_mem i_cbd_code_mem (.*);
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction; on rst load program (byte 0 rightmost) and reset
  task automatic step(input logic rst, input logic [127:0] p, input logic [6:0] ef,
                      input logic [15:0] ea, input int en);
    int n;
    if (rst) begin
      for (int i = 0; i < 16; i++) i_cbd_code_mem.mem[i] = p[8*i+:8];
      reset_n <= 1'b0;
      @(posedge clk) reset_n <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (instr_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      give_verdict();
    end
    fl = {push_we, pop_req, int_level_end, bit_we, reg_we, dir_we, other_op};
    pp = push_pc;
    bw = bit_wdata;
    rw = reg_wdata;
    rn = reg_no;
    ba = bit_addr;
    @(posedge clk);
    #1 cy = carry;
    chk("flags", ef, fl);
    chk("next fetch", ea, code_addr);
    if (en > 0) chk("cycles", en, n);
    @(posedge clk);
  endtask
  task automatic t_carry;
    step(1, 96'h05a2_0792_05a0_05b0_0572_05a2, 0, 2, 0);
    chk("carry", 0, cy);
    bit_value <= 1'b1;
    step(0, 0, 0, 4, 3);
    chk("carry", 1, cy);
    step(0, 0, 0, 6, 3);
    chk("carry", 0, cy);
    bit_value <= 1'b0;
    step(0, 0, 0, 8, 3);
    chk("carry", 1, cy);
    step(0, 0, 7'h08, 10, 3);
    chk("bit data", 1, bw);
    chk("bit addr", 8'h07, ba);
    step(0, 0, 0, 12, 2);
    chk("carry", 0, cy);
    step(0, 0, 0, 13, 2);
    $display("t_carry done");
  endtask
  task automatic t_jump;
    step(1, 24'h341202, 0, 16'h1234, 0);
    step(1, 24'hcdab12, 7'h40, 16'habcd, 0);
    chk("push pc", 3, pp);
    step(1, 16'h56e1, 0, 16'h0756, 0);
    step(1, 16'h22f1, 7'h40, 16'h0722, 0);
    chk("push pc", 2, pp);
    step(1, 16'hfe80, 0, 0, 0);
    acc <= 8'h10;
    data_pointer <= 16'h1000;
    step(1, 8'h73, 0, 16'h1010, 0);
    stack_pc <= 16'h0345;
    step(1, 8'h22, 7'h20, 16'h0345, 0);
    step(1, 8'h32, 7'h30, 16'h0345, 0);
    $display("t_jump done");
  endtask
  task automatic t_cond;
    bit_value <= 1'b1;
    step(1, 24'h050720, 0, 8, 0);
    step(1, 24'h050730, 0, 3, 0);
    step(1, 24'h050710, 7'h08, 8, 0);
    chk("bit data", 0, bw);
    acc <= 8'h00;
    step(1, 16'h1060, 0, 16'h0012, 0);
    step(1, 16'h1070, 0, 2, 0);
    $display("t_cond done");
  endtask
  task automatic t_loop;
    acc <= 8'h03;
    step(1, 24'h0305b4, 0, 6, 0);
    chk("carry", 1, cy);
    operand_value <= 8'h03;
    step(1, 24'h0540b5, 0, 3, 0);
    operand_value <= 8'h01;
    step(1, 16'h04d9, 7'h04, 2, 0);
    chk("reg no", 1, rn);
    chk("reg data", 0, rw);
    operand_value <= 8'h02;
    step(1, 24'h0408d5, 7'h02, 7, 0);
    step(1, 8'he0, 0, 1, 0);
    step(1, 8'hf2, 0, 1, 0);
    step(1, 8'h04, 7'h01, 1, 0);
    $display("t_loop done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    t_carry();
    t_jump();
    t_cond();
    t_loop();
    give_verdict();
  end
endmodule // test_cbd_core
